//--- hw/pssp_top.sv
// Strap capture and status pin logic for a PHY's address/LED and mode pins.
// Assumes pins arrive asynchronous; activity inputs are on core_clk.
//
// How it works
// - During reset the transmit-LED pin is an input, captured as address bit 3.
// - Address straps are captured in both hardware and software mode.
// - After reset the transmit-LED pin drives, high while transmit activity.
// - During reset the receive-LED pin is an input, captured as address bit 4.
// - Receive-LED pin is input only in reset, output afterwards.
// - After reset the receive-LED output is high while receive activity.
// - Speed and autoneg select pins are inputs in hardware, outputs in software.
// - Hardware mode: speed pin low gives 10 Mb/s, high gives 100 Mb/s.
// - Software mode: speed pin driven low for 10, high for 100 Mb/s.
// - Hardware mode: autoneg pin high enables, low disables auto-negotiation.
// - Software mode: autoneg pin driven high when enabled, low when disabled.
// - A dedicated input, pulled up outside, enables crossover correction.
// - Mode select pin low selects hardware mode, high selects software mode.
// - Three more straps give address bits 0 to 2 the same way.
`timescale 1ns/1ps
`include "pssp_consts.svh"
module pssp_top
  import pssp_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [`PSSP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`PSSP_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PSSP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`PSSP_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Hardware reset pin
  input wire logic hw_reset_n,
  // Address strap / LED pins
  input wire logic addr0_activity_led_i,
  output logic addr0_activity_led_o,
  output logic addr0_activity_led_oe_n,
  input wire logic addr1_collision_led_i,
  output logic addr1_collision_led_o,
  output logic addr1_collision_led_oe_n,
  input wire logic addr2_link_led_i,
  output logic addr2_link_led_o,
  output logic addr2_link_led_oe_n,
  input wire logic addr3_tx_led_i,
  output logic addr3_tx_led_o,
  output logic addr3_tx_led_oe_n,
  input wire logic addr4_rx_led_i,
  output logic addr4_rx_led_o,
  output logic addr4_rx_led_oe_n,
  // Mode pins
  input wire logic speed_select_i,
  output logic speed_select_o,
  output logic speed_select_oe_n,
  input wire logic autoneg_select_i,
  output logic autoneg_select_o,
  output logic autoneg_select_oe_n,
  input wire logic hardware_software_select,
  input wire logic crossover_correct_enable,
  // Activity from the PHY core
  input wire logic tx_activity,
  input wire logic rx_activity,
  input wire logic collision,
  input wire logic link_up,
  // Resolved configuration to the PHY core
  output logic [4:0] phy_address,
  output logic phy_in_reset,
  output logic sw_mode,
  output logic speed_100,
  output logic autoneg_enable,
  output logic crossover_enable
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  pssp_pins_s pins_raw;
  pssp_pins_s pins_s;

  assign pins_raw.hw_reset_n = hw_reset_n;
  assign pins_raw.hws = hardware_software_select;
  assign pins_raw.xover = crossover_correct_enable;
  assign pins_raw.an = autoneg_select_i;
  assign pins_raw.spd = speed_select_i;
  assign pins_raw.addr = {addr4_rx_led_i, addr3_tx_led_i, addr2_link_led_i,
                          addr1_collision_led_i, addr0_activity_led_i};

  pssp_sync #(
    .W($bits(pssp_pins_s))
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Strap phase sequencer

  pssp_state_e st_q;
  logic [1:0] settle_q;

  // Power-on reset enters here directly; the hardware reset pin re-enters
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= ST_SETTLE;
      settle_q <= 2'h0;
    end
    else if (clk_en)
    begin
      case (st_q)
        ST_SETTLE:
        begin
          if (settle_q == `PSSP_SETTLE_CYCLES - 2'h1)
          begin
            st_q <= ST_CAPTURE;
            settle_q <= 2'h0;
          end
          else
          begin
            settle_q <= settle_q + 2'h1;
          end
        end
        ST_CAPTURE:
        begin
          if (pins_s.hw_reset_n)
          begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (!pins_s.hw_reset_n)
          begin
            st_q <= ST_SETTLE;
          end
        end
        default:
        begin
          st_q <= ST_SETTLE;
          settle_q <= 2'h0;
        end
      endcase
    end
  end

  assign phy_in_reset = (st_q != ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Address strap capture

  logic [4:0] addr_q;

  // Mode is not consulted; held once running
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_q <= 5'h00;
    end
    else if (clk_en && st_q == ST_CAPTURE)
    begin
      addr_q <= pins_s.addr;
    end
  end

  assign phy_address = addr_q;

  ////////////////////////////////////////////////////////////////////////
  // LED drive

  logic [4:0] led_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      led_q <= 5'h00;
    end
    else if (clk_en)
    begin
      led_q[0] <= tx_activity | rx_activity;
      led_q[1] <= collision;
      led_q[2] <= link_up;
      led_q[3] <= tx_activity;
      led_q[4] <= rx_activity;
    end
  end

  assign addr0_activity_led_o = led_q[0];
  assign addr1_collision_led_o = led_q[1];
  assign addr2_link_led_o = led_q[2];
  assign addr3_tx_led_o = led_q[3];
  assign addr4_rx_led_o = led_q[4];
  // Strap pins float back to inputs for the whole strap phase
  assign addr0_activity_led_oe_n = phy_in_reset;
  assign addr1_collision_led_oe_n = phy_in_reset;
  assign addr2_link_led_oe_n = phy_in_reset;
  assign addr3_tx_led_oe_n = phy_in_reset;
  assign addr4_rx_led_oe_n = phy_in_reset;

  ////////////////////////////////////////////////////////////////////////
  // Mode pins and resolved configuration

  pssp_ctrl_s ctrl_q;
  logic sw_q;
  logic spd_q;
  logic an_q;
  logic xover_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sw_q <= 1'b0;
      spd_q <= 1'b0;
      an_q <= 1'b0;
      xover_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sw_q <= pins_s.hws;
      spd_q <= sw_q ? ctrl_q.speed_100 : pins_s.spd;
      an_q <= sw_q ? ctrl_q.autoneg_en : pins_s.an;
      xover_q <= pins_s.xover;
    end
  end

  assign sw_mode = sw_q;
  assign speed_100 = spd_q;
  assign autoneg_enable = an_q;
  assign crossover_enable = xover_q;
  assign speed_select_o = spd_q;
  assign autoneg_select_o = an_q;
  assign speed_select_oe_n = !sw_q;
  assign autoneg_select_oe_n = !sw_q;

  ////////////////////////////////////////////////////////////////////////
  // Register bus slave

  logic aw_have_q;
  logic w_have_q;
  logic [`PSSP_ADDR_W-1:0] awaddr_q;
  logic [`PSSP_DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [`PSSP_DATA_W-1:0] rdata_q;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_ok;
  logic [`PSSP_DATA_W-1:0] rd_word;
  logic rd_ok;
  logic [`PSSP_ADDR_W-1:0] awaddr_w;
  logic [`PSSP_ADDR_W-1:0] araddr_w;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Sub-word bits of the address are ignored
  assign awaddr_w = {awaddr_q[`PSSP_ADDR_W-1:`PSSP_WORD_LSB], 2'h0};
  assign araddr_w = {s_axi_araddr[`PSSP_ADDR_W-1:`PSSP_WORD_LSB], 2'h0};
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ctrl = (awaddr_w == `PSSP_OFS_CTRL);
  assign wr_ok = wr_ctrl || (awaddr_w == `PSSP_OFS_STATUS);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `PSSP_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `PSSP_RESP_OKAY : `PSSP_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control word steers the mode pins in software mode
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= `PSSP_CTRL_RESET;
    end
    else if (clk_en && wr_fire && wr_ctrl && wstrb_q[0])
    begin
      ctrl_q.speed_100 <= wdata_q[`PSSP_CTRL_SPEED_BIT];
      ctrl_q.autoneg_en <= wdata_q[`PSSP_CTRL_AN_BIT];
    end
  end

  always_comb
  begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (araddr_w)
      `PSSP_OFS_CTRL:
      begin
        rd_word[`PSSP_CTRL_SPEED_BIT] = ctrl_q.speed_100;
        rd_word[`PSSP_CTRL_AN_BIT] = ctrl_q.autoneg_en;
      end
      `PSSP_OFS_STATUS:
      begin
        rd_word[`PSSP_ST_ADDR_MSB:0] = addr_q;
        rd_word[`PSSP_ST_SW_BIT] = sw_q;
        rd_word[`PSSP_ST_SPEED_BIT] = spd_q;
        rd_word[`PSSP_ST_AN_BIT] = an_q;
        rd_word[`PSSP_ST_XOVER_BIT] = xover_q;
        rd_word[`PSSP_ST_BUSY_BIT] = phy_in_reset;
      end
      default:
      begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= `PSSP_RESP_OKAY;
      rdata_q <= '0;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? `PSSP_RESP_OKAY : `PSSP_RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_strap_release: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q == ST_RUN && !pins_s.hw_reset_n) |=>
      (addr3_tx_led_oe_n && addr4_rx_led_oe_n && addr0_activity_led_oe_n))
    else $error("strap pins not released on hardware reset");

  chk_addr_capture: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q == ST_CAPTURE) |=> (phy_address == $past(pins_s.addr)))
    else $error("strap address not captured");

  chk_addr_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (st_q == ST_RUN) ##1 (st_q == ST_RUN) |-> $stable(phy_address))
    else $error("address changed while running");

  chk_tx_led_follow: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q == ST_RUN) |=>
      (addr3_tx_led_o == $past(tx_activity)))
    else $error("transmit LED does not follow activity");

  chk_rx_led_follow: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && st_q == ST_RUN) |=>
      (addr4_rx_led_o == $past(rx_activity)))
    else $error("receive LED does not follow activity");

  chk_mode_pin_dir: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en |=> (speed_select_oe_n == !$past(pins_s.hws)
                && autoneg_select_oe_n == !$past(pins_s.hws)))
    else $error("mode pin direction does not follow mode select");

  chk_speed_hw: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && !sw_q) |=> (speed_100 == $past(pins_s.spd)))
    else $error("hardware speed select not applied");

  chk_speed_sw: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && sw_q) |=> (speed_select_o == $past(ctrl_q.speed_100)))
    else $error("software speed not driven on pin");

  chk_an_hw: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && !sw_q) |=> (autoneg_enable == $past(pins_s.an)))
    else $error("hardware autoneg select not applied");

  chk_an_sw: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && sw_q) |=> (autoneg_select_o == $past(ctrl_q.autoneg_en)))
    else $error("software autoneg not driven on pin");

  chk_xover_follow: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en |=> (crossover_enable == $past(pins_s.xover)))
    else $error("crossover enable does not follow input");

endmodule // pssp_top

//--- hw/pssp_consts.svh
// Constants for the strap and status pin block: register map, fields,
// reset values and counts.
// Assumes inclusion by bare name from files under hw/.
`ifndef PSSP_CONSTS_SVH
`define PSSP_CONSTS_SVH

// Register bus geometry
`define PSSP_ADDR_W 8
`define PSSP_DATA_W 32
`define PSSP_WORD_LSB 2

// Register byte offsets
`define PSSP_OFS_CTRL 8'h00
`define PSSP_OFS_STATUS 8'h04

// Control register fields and reset value
`define PSSP_CTRL_SPEED_BIT 0
`define PSSP_CTRL_AN_BIT 1
`define PSSP_CTRL_RESET 2'h3

// Status register fields
`define PSSP_ST_ADDR_MSB 4
`define PSSP_ST_SW_BIT 8
`define PSSP_ST_SPEED_BIT 9
`define PSSP_ST_AN_BIT 10
`define PSSP_ST_XOVER_BIT 11
`define PSSP_ST_BUSY_BIT 12

// Responses
`define PSSP_RESP_OKAY 2'h0
`define PSSP_RESP_SLVERR 2'h2

// Cycles that released strap pins settle through the synchroniser
`define PSSP_SETTLE_CYCLES 2'h3

// Reset value of the synchronised pin group
`define PSSP_PINS_RESET 10'h000

`endif

//--- hw/pssp_pkg.sv
// Types for the strap and status pin block.
// Assumes nothing beyond a SystemVerilog compiler.
package pssp_pkg;

  // Strap phase, then normal running
  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_CAPTURE = 2'h1,
    ST_RUN = 2'h3
  } pssp_state_e;

  // Software-written configuration
  typedef struct packed {
    logic autoneg_en;
    logic speed_100;
  } pssp_ctrl_s;

  // Pin inputs after synchronisation
  typedef struct packed {
    logic hw_reset_n;
    logic hws;
    logic xover;
    logic an;
    logic spd;
    logic [4:0] addr;
  } pssp_pins_s;

endpackage

//--- hw/pssp_sync.sv
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level; no bus coherency is implied.
`timescale 1ns/1ps
module pssp_sync
  import pssp_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // pssp_sync

//--- tb/pssp_board.sv
// Board model: strap resistors and indicator LEDs on the pin pads.
// Assumes each pad is split into input, output and an active-low enable.
`timescale 1ns/1ps
module pssp_board
  import pssp_pkg::*;
(
  // Strap levels set by the board
  input wire logic [4:0] strap_addr,
  input wire logic strap_speed,
  input wire logic strap_an,
  // Device side of the pads
  input wire logic [4:0] led_o,
  input wire logic [4:0] led_oe_n,
  input wire logic spd_o,
  input wire logic spd_oe_n,
  input wire logic an_o,
  input wire logic an_oe_n,
  // Resolved pad levels
  output logic [4:0] led_pin,
  output logic spd_pin,
  output logic an_pin
);
  // A released pad sits at its resistor level, never floating
  always_comb
  begin
    for (int i = 0; i < 5; i++)
      led_pin[i] = led_oe_n[i] ? strap_addr[i] : led_o[i];
  end
  assign spd_pin = spd_oe_n ? strap_speed : spd_o;
  assign an_pin = an_oe_n ? strap_an : an_o;
endmodule // pssp_board

//--- tb/tb_top.sv
// Testbench for the strap and status pin block.
// Assumes the board model pssp_board and a 100 MHz core clock.
`timescale 1ns/1ps
`include "pssp_consts.svh"
module tb_top
  import pssp_pkg::*;
;
  logic core_clk, sys_rst, hw_reset_n, hws, xover;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic tx_act, rx_act, strap_spd, strap_an, col, link, clk_en;
  logic [4:0] strap, led_o, led_oe_n, led_pin, phy_address;
  logic spd_o, spd_oe_n, an_o, an_oe_n, spd_pin, an_pin;
  logic phy_in_reset, sw_mode, speed_100, autoneg_enable, crossover_enable;
  logic [31:0] rd;
  logic [1:0] rsp;
  int bad_count, n_compared;

  pssp_top dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hw_reset_n(hw_reset_n),
    .addr0_activity_led_i(led_pin[0]), .addr0_activity_led_o(led_o[0]),
    .addr0_activity_led_oe_n(led_oe_n[0]),
    .addr1_collision_led_i(led_pin[1]), .addr1_collision_led_o(led_o[1]),
    .addr1_collision_led_oe_n(led_oe_n[1]),
    .addr2_link_led_i(led_pin[2]), .addr2_link_led_o(led_o[2]),
    .addr2_link_led_oe_n(led_oe_n[2]),
    .addr3_tx_led_i(led_pin[3]), .addr3_tx_led_o(led_o[3]),
    .addr3_tx_led_oe_n(led_oe_n[3]),
    .addr4_rx_led_i(led_pin[4]), .addr4_rx_led_o(led_o[4]),
    .addr4_rx_led_oe_n(led_oe_n[4]),
    .speed_select_i(spd_pin), .speed_select_o(spd_o),
    .speed_select_oe_n(spd_oe_n), .autoneg_select_i(an_pin),
    .autoneg_select_o(an_o), .autoneg_select_oe_n(an_oe_n),
    .hardware_software_select(hws), .crossover_correct_enable(xover),
    .tx_activity(tx_act), .rx_activity(rx_act), .collision(col),
    .link_up(link), .phy_address(phy_address), .phy_in_reset(phy_in_reset),
    .sw_mode(sw_mode), .speed_100(speed_100),
    .autoneg_enable(autoneg_enable), .crossover_enable(crossover_enable)
  );

  pssp_board board (
    .strap_addr(strap), .strap_speed(strap_spd), .strap_an(strap_an),
    .led_o(led_o), .led_oe_n(led_oe_n), .spd_o(spd_o), .spd_oe_n(spd_oe_n),
    .an_o(an_o), .an_oe_n(an_oe_n), .led_pin(led_pin), .spd_pin(spd_pin),
    .an_pin(an_pin)
  );

  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Leaves the strap phase within a bounded number of cycles
  task wait_run;
    int t;
    for (t = 0; t < 40 && phy_in_reset !== 1'b0; t++)
      cyc(1);
    chk("strap phase end", 32'h0, {31'h0, phy_in_reset});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 50; t++)
    begin
      @(posedge core_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    chk("write answered", 32'h1, {31'h0, t < 50});
    #1;
  endtask

  task axi_read(input logic [7:0] a);
    int t;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 50; t++)
    begin
      @(posedge core_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    chk("read answered", 32'h1, {31'h0, t < 50});
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 0;
    sys_rst = 1;
    hw_reset_n = 1;
    hws = 0;
    xover = 1;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = '0;
    wstrb = 4'hf;
    {tx_act, rx_act, strap_spd, col, link} = '0;
    clk_en = 1;
    strap_an = 1;
    strap = 5'h15;
    cyc(1);
    chk("led enables in reset", 32'h1f, led_oe_n);
    repeat (4) @(posedge core_clk);
    sys_rst <= 0;
    wait_run;
    chk("strap address", 32'h15, phy_address);
    chk("led enables run", 32'h0, led_oe_n);
    chk("mode pin enables hw", 32'h3, {spd_oe_n, an_oe_n});
    chk("hw speed low", 32'h0, speed_100);
    chk("hw autoneg high", 32'h1, autoneg_enable);
    chk("crossover on", 32'h1, crossover_enable);
    $display("Test straps done");

    // Activity lamps, then straps changed by the board after reset
    @(posedge core_clk);
    tx_act <= 1;
    col <= 1;
    strap <= 5'h0a;
    cyc(2);
    chk("tx leds", 32'h0b, led_pin);
    @(posedge core_clk);
    tx_act <= 0;
    rx_act <= 1;
    col <= 0;
    link <= 1;
    cyc(2);
    chk("rx leds", 32'h15, led_pin);
    // Clock enable low must hold the lamps although activity has gone
    @(posedge core_clk);
    rx_act <= 0;
    link <= 0;
    clk_en <= 0;
    cyc(3);
    chk("leds frozen", 32'h15, led_pin);
    @(posedge core_clk);
    clk_en <= 1;
    cyc(2);
    chk("leds idle", 32'h0, led_pin);
    chk("address held", 32'h15, phy_address);
    $display("Test leds done");

    // Hardware mode pin levels
    @(posedge core_clk);
    strap_spd <= 1;
    strap_an <= 0;
    xover <= 0;
    cyc(5);
    chk("hw speed high", 32'h1, speed_100);
    chk("hw autoneg low", 32'h0, autoneg_enable);
    chk("crossover off", 32'h0, crossover_enable);
    axi_read(`PSSP_OFS_STATUS);
    chk("status hw", 32'h215, rd);
    $display("Test hardware mode done");

    // Hardware reset while in software mode
    @(posedge core_clk);
    hws <= 1;
    xover <= 1;
    hw_reset_n <= 0;
    cyc(5);
    chk("strap phase", 32'h1, phy_in_reset);
    chk("led enables hw reset", 32'h1f, led_oe_n);
    @(posedge core_clk);
    hw_reset_n <= 1;
    wait_run;
    chk("sw strap address", 32'h0a, phy_address);
    chk("sw mode", 32'h1, sw_mode);
    chk("mode pin enables sw", 32'h0, {spd_oe_n, an_oe_n});
    chk("sw pins reset", 32'h3, {spd_pin, an_pin});
    axi_write(`PSSP_OFS_CTRL, 32'h0);
    cyc(3);
    chk("sw pins 10 no an", 32'h0, {spd_pin, an_pin});
    chk("sw speed", 32'h0, speed_100);
    axi_write(`PSSP_OFS_CTRL, 32'h1);
    cyc(3);
    chk("sw pins 100 no an", 32'h2, {spd_pin, an_pin});
    axi_read(`PSSP_OFS_STATUS);
    chk("status sw", 32'hb0a, rd);
    $display("Test software mode done");

    // Register bus responses
    axi_write(`PSSP_OFS_STATUS, 32'hffff);
    chk("status write resp", 32'h0, rsp);
    axi_read(`PSSP_OFS_CTRL);
    chk("ctrl readback", 32'h1, rd);
    axi_write(8'h10, 32'h3);
    chk("unmapped write resp", 32'h2, rsp);
    axi_read(8'h10);
    chk("unmapped read", 32'h2, {rd[29:0], rsp});
    // Control write without its low byte strobe leaves the word alone
    @(posedge core_clk);
    wstrb <= 4'he;
    axi_write(`PSSP_OFS_CTRL, 32'h2);
    chk("ctrl no strobe resp", 32'h0, rsp);
    axi_read(`PSSP_OFS_CTRL);
    chk("ctrl no strobe", 32'h1, rd);
    $display("Test register bus done");
    give_verdict;
  end

  initial
  begin
    #20us;
    bad_count++;
    $display("[FAIL] watchdog expected done seen hang");
    give_verdict;
  end
endmodule // tb_top
